// >>> hdl/srt_pkg.sv
package srt_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int unsigned IDX_W   = 6;
	localparam int unsigned ADDR_W  = 7;
	localparam logic [5:0]  MAX_IDX = 6'h3F;

	// ****************************************
	// track parameter set
	// ****************************************
	typedef struct packed {
		logic [6:0] primary_start_sentinel;
		logic [6:0] alternate_start_sentinel;
		logic [6:0] primary_end_sentinel;
		logic [6:0] alternate_end_sentinel;
		logic [2:0] char_bits;
	} srt_parm_t;

	localparam srt_parm_t T1_DEF = '{7'h05, 7'h05, 7'h1F, 7'h1F, 3'h7};
	localparam srt_parm_t T2_DEF = '{7'h0B, 7'h0D, 7'h0F, 7'h0C, 3'h5};
	localparam logic [2:0] BITS_SEVEN = 3'h7;
	localparam logic [7:0] MASK_SEVEN = 8'h7F;
	localparam logic [7:0] MASK_FIVE  = 8'h1F;

	// ****************************************
	// status byte and length
	// ****************************************
	localparam int unsigned ST_BLANK = 7;
	localparam int unsigned ST_ERR   = 6;
	localparam int unsigned ST_T1    = 2;
	localparam int unsigned ST_T2    = 1;
	localparam logic [7:0]  LEN_UNREAD = 8'h01;

	// ****************************************
	// policy and states
	// ****************************************
	localparam logic POL_ALL = 1'b0;
	localparam logic POL_ANY = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ARMED = 3'b010,
		ST_EMIT  = 3'b100
	} srt_state_t;

	typedef enum logic [2:0] {
		PH_LEN  = 3'b001,
		PH_STAT = 3'b010,
		PH_DATA = 3'b100
	} srt_phase_t;

	typedef enum logic [3:0] {
		CK_SEEK = 4'b0001,
		CK_DATA = 4'b0010,
		CK_LRC  = 4'b0100,
		CK_DONE = 4'b1000
	} srt_ck_t;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic       strobe;
		logic       active;
		logic       trk;
		logic [7:0] chr;
	} srt_head_t;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} srt_rec_t;

endpackage : srt_pkg

// >>> hdl/srt_trk_mem.sv
`timescale 1ns/1ps
`default_nettype none
module srt_trk_mem import srt_pkg::*; (
	// clock
	input  wire logic              ref_clk,
	// write side
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [7:0]        wr_data,
	// read side
	input  wire logic [ADDR_W-1:0] rd_addr,
	output var  logic [7:0]        rd_data_ff
);
	logic [7:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_ff <= mem[rd_addr];
	end
endmodule : srt_trk_mem
`default_nettype wire

// >>> hdl/srt_read_ctrl.sv
// Functional notes
// - all-track policy: validate every requested track first
// - all-track policy: any bad track fails, indicator on
// - failed read stays pending until success or abort
// - any-track policy: done when one track valid
// - any-track policy: failed tracks carry failure status
// - session open loads defaults for every track
// - track one: 05/1F, seven bits, odd, even LRC
// - track two: 0B|0D, 0F|0C, five bits
// - host-loaded parameters replace defaults
// - single track: indicator on at arm, on fail
// - indicator stays lit until a successful read or an abort
// - abort cancels read and clears indicator
// - status: bit7 blank, bit6 error, bits 2/1 track
// - length byte: status plus data, 01 unread
// - either primary or alternate sentinel accepted
`timescale 1ns/1ps
`default_nettype none
module srt_read_ctrl import srt_pkg::*; (
	// clock and reset
	input  wire logic      ref_clk,
	input  wire logic      rst_b,
	// read head pins
	input  wire srt_head_t head_pins,
	// host control
	input  wire logic      open_reader_session,
	input  wire logic      load_track_parameters,
	input  wire logic      load_track_sel,
	input  wire srt_parm_t load_parm,
	input  wire logic      set_multitrack_policy,
	input  wire logic      multitrack_policy,
	input  wire logic      track_read_request,
	input  wire logic [1:0] requested_track_set,
	input  wire logic      abort_track_read,
	// host answers
	output var  srt_rec_t  rec_out,
	output var  logic      read_done,
	output var  logic      read_busy,
	output var  logic      failure_indicator
);
	// ****************************************
	// declarations
	// ****************************************
	srt_head_t  hd_s1_ff, hd_s2_ff, hd_prev_ff;
	srt_parm_t  parm_ff [2];
	logic       pol_ff;
	srt_state_t st_ff;
	logic [1:0] req_ff;
	logic       ind_ff;
	srt_ck_t    ck_ff [2];
	logic [1:0] err_ff;
	logic [5:0] cnt_ff [2];
	logic [6:0] lrc_ff [2];
	logic [1:0] ok_ff;
	logic [7:0] stat_ff [2];
	srt_phase_t ph_ff;
	logic       cur_ff;
	logic [5:0] idx_ff;
	srt_rec_t   rec_ff;
	logic       done_ff;
	logic       busy_ff;
	logic [7:0] mem_q;
	srt_parm_t  p;
	logic [7:0] pm, c;
	logic [6:0] d;
	logic       tk, par_ok, chr_go, sw_go, req_go, pass, ck_clr;
	logic       wr_en, last_trk, emit_end;
	logic [1:0] ok_now;
	logic [5:0] ndata;
	logic [ADDR_W-1:0] rd_addr;

	function automatic logic sent_hit(input logic [6:0] v,
		input logic [6:0] a, input logic [6:0] b);
		return (v == a) || (v == b);
	endfunction : sent_hit

	// ****************************************
	// head pin synchroniser and edges
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hd_s1_ff   <= '0;
			hd_s2_ff   <= '0;
			hd_prev_ff <= '0;
		end else begin
			hd_s1_ff   <= head_pins;
			hd_s2_ff   <= hd_s1_ff;
			hd_prev_ff <= hd_s2_ff;
		end
	end

	// ****************************************
	// character decode
	// ****************************************
	always_comb begin
		tk     = hd_s2_ff.trk;
		p      = parm_ff[tk];
		pm     = (p.char_bits == BITS_SEVEN) ? MASK_SEVEN : MASK_FIVE;
		c      = hd_s2_ff.chr & pm;
		d      = c[6:0] & pm[7:1];
		par_ok = ^c;
		req_go = track_read_request && (requested_track_set != 2'b00);
		chr_go = (st_ff == ST_ARMED) && hd_s2_ff.strobe && !hd_prev_ff.strobe;
		sw_go  = (st_ff == ST_ARMED) && !hd_s2_ff.active && hd_prev_ff.active;
		for (int t = 0; t < 2; t++) begin
			ok_now[t] = (ck_ff[t] == CK_DONE) && !err_ff[t];
		end
		if (pol_ff == POL_ALL) begin
			pass = ((ok_now & req_ff) == req_ff);
		end else begin
			pass = |(ok_now & req_ff);
		end
		ck_clr = ((st_ff == ST_IDLE) && req_go) || (sw_go && !pass);
		wr_en  = chr_go && par_ok && (((ck_ff[tk] == CK_SEEK) &&
			sent_hit(d, p.primary_start_sentinel,
			p.alternate_start_sentinel)) ||
			((ck_ff[tk] == CK_DATA) && (cnt_ff[tk] != MAX_IDX)));
	end

	// ****************************************
	// parameters and policy
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			parm_ff[0] <= T1_DEF;
			parm_ff[1] <= T2_DEF;
			pol_ff     <= POL_ALL;
		end else begin
			if (open_reader_session) begin
				parm_ff[0] <= T1_DEF;
				parm_ff[1] <= T2_DEF;
			end else if (load_track_parameters) begin
				parm_ff[load_track_sel] <= load_parm;
			end
			if (set_multitrack_policy) begin
				pol_ff <= multitrack_policy;
			end
		end
	end

	// ****************************************
	// per-track validity checker
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int t = 0; t < 2; t++) begin
				ck_ff[t]  <= CK_SEEK;
				cnt_ff[t] <= '0;
				lrc_ff[t] <= '0;
			end
			err_ff <= '0;
		end else if (ck_clr) begin
			for (int t = 0; t < 2; t++) begin
				ck_ff[t]  <= CK_SEEK;
				cnt_ff[t] <= '0;
				lrc_ff[t] <= '0;
			end
			err_ff <= '0;
		end else if (chr_go) begin
			case (ck_ff[tk])
				CK_SEEK: begin
					if (wr_en) begin
						ck_ff[tk]  <= CK_DATA;
						cnt_ff[tk] <= 6'h01;
						lrc_ff[tk] <= d;
					end
				end
				CK_DATA: begin
					if (!wr_en) begin
						err_ff[tk] <= 1'b1;
						ck_ff[tk]  <= CK_DONE;
					end else begin
						cnt_ff[tk] <= cnt_ff[tk] + 6'h01;
						lrc_ff[tk] <= lrc_ff[tk] ^ d;
						if (sent_hit(d, p.primary_end_sentinel,
							p.alternate_end_sentinel)) begin
							ck_ff[tk] <= CK_LRC;
						end
					end
				end
				CK_LRC: begin
					err_ff[tk] <= par_ok || (d != lrc_ff[tk]);
					ck_ff[tk]  <= CK_DONE;
				end
				CK_DONE: begin
					ck_ff[tk] <= CK_DONE;
				end
				default: begin
					ck_ff[tk] <= CK_SEEK;
				end
			endcase
		end
	end

	// ****************************************
	// status snapshot at swipe end
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ok_ff      <= '0;
			stat_ff[0] <= '0;
			stat_ff[1] <= '0;
		end else if (sw_go) begin
			ok_ff <= ok_now;
			for (int t = 0; t < 2; t++) begin
				stat_ff[t]           <= '0;
				stat_ff[t][ST_BLANK] <= (ck_ff[t] == CK_SEEK);
				stat_ff[t][ST_ERR]   <= !ok_now[t] && (ck_ff[t] != CK_SEEK);
				stat_ff[t][ST_T1]    <= (t == 0);
				stat_ff[t][ST_T2]    <= (t == 1);
			end
		end
	end

	// ****************************************
	// request sequencer
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff   <= ST_IDLE;
			req_ff  <= '0;
			busy_ff <= 1'b0;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (req_go) begin
						st_ff   <= ST_ARMED;
						req_ff  <= requested_track_set;
						busy_ff <= 1'b1;
					end
				end
				ST_ARMED: begin
					if (abort_track_read) begin
						st_ff   <= ST_IDLE;
						busy_ff <= 1'b0;
					end else if (sw_go && pass) begin
						st_ff <= ST_EMIT;
					end
				end
				ST_EMIT: begin
					if (abort_track_read || emit_end) begin
						st_ff   <= ST_IDLE;
						busy_ff <= 1'b0;
					end
				end
				default: begin
					st_ff   <= ST_IDLE;
					busy_ff <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// failure indicator
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ind_ff <= 1'b0;
		end else if (abort_track_read && (st_ff != ST_IDLE)) begin
			ind_ff <= 1'b0;
		end else if ((st_ff == ST_IDLE) && req_go &&
			(requested_track_set != 2'b11)) begin
			ind_ff <= 1'b1;
		end else if (sw_go) begin
			ind_ff <= !pass;
		end
	end

	// ****************************************
	// record emitter
	// ****************************************
	always_comb begin
		ndata    = ok_ff[cur_ff] ? cnt_ff[cur_ff] : 6'h00;
		last_trk = cur_ff || !req_ff[1];
		emit_end = (st_ff == ST_EMIT) && last_trk &&
			(((ph_ff == PH_STAT) && (ndata == 6'h00)) ||
			((ph_ff == PH_DATA) && (idx_ff == ndata - 6'h01)));
		rd_addr  = {cur_ff, (ph_ff == PH_STAT) ? 6'h00 : idx_ff + 6'h01};
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_ff   <= PH_LEN;
			cur_ff  <= 1'b0;
			idx_ff  <= '0;
			rec_ff  <= '0;
			done_ff <= 1'b0;
		end else if (st_ff != ST_EMIT || abort_track_read) begin
			ph_ff   <= PH_LEN;
			cur_ff  <= !req_ff[0];
			idx_ff  <= '0;
			rec_ff  <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= emit_end;
			case (ph_ff)
				PH_LEN: begin
					rec_ff <= {1'b1, 1'b0, ok_ff[cur_ff] ?
						{2'b00, cnt_ff[cur_ff]} + 8'h01 : LEN_UNREAD};
					ph_ff  <= PH_STAT;
				end
				PH_STAT: begin
					rec_ff <= {1'b1, emit_end, stat_ff[cur_ff]};
					idx_ff <= '0;
					if (ndata != 6'h00) begin
						ph_ff <= PH_DATA;
					end else begin
						ph_ff  <= PH_LEN;
						cur_ff <= 1'b1;
					end
				end
				PH_DATA: begin
					rec_ff <= {1'b1, emit_end, mem_q};
					idx_ff <= idx_ff + 6'h01;
					if (idx_ff == ndata - 6'h01) begin
						ph_ff  <= PH_LEN;
						cur_ff <= 1'b1;
					end
				end
				default: begin
					ph_ff <= PH_LEN;
				end
			endcase
		end
	end

	srt_trk_mem u_mem (
		.ref_clk    (ref_clk),
		.wr_en      (wr_en),
		.wr_addr    ({tk, cnt_ff[tk]}),
		.wr_data    ({1'b0, d}),
		.rd_addr    (rd_addr),
		.rd_data_ff (mem_q)
	);

	assign rec_out           = rec_ff;
	assign read_done         = done_ff;
	assign read_busy         = busy_ff;
	assign failure_indicator = ind_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_unread_len;
		rec_ff.valid && (rec_ff.data == LEN_UNREAD);
	endsequence
	sequence s_fail_stat;
		rec_ff.valid && (rec_ff.data[ST_BLANK] || rec_ff.data[ST_ERR]);
	endsequence

	AST_ALL_CHECKED: assert property (
		(st_ff == ST_EMIT && pol_ff == POL_ALL) |-> ((ok_ff & req_ff) == req_ff))
		else $error("all-track emit with invalid track");
	AST_ALL_FAIL: assert property (
		(sw_go && !pass && pol_ff == POL_ALL && !abort_track_read) |=> ind_ff)
		else $error("indicator not lit on failed read");
	AST_PENDING: assert property (
		(sw_go && !pass && !abort_track_read) |=> (st_ff == ST_ARMED))
		else $error("request dropped after failed read");
	AST_ANY_DONE: assert property (
		(sw_go && pol_ff == POL_ANY && |(ok_now & req_ff) && !abort_track_read)
		|=> (st_ff == ST_EMIT) ##1 rec_ff.valid)
		else $error("any-track read did not complete");
	AST_UNREAD_REC: assert property (
		(st_ff == ST_EMIT && ph_ff == PH_LEN && !ok_ff[cur_ff] &&
		!abort_track_read) |=> s_unread_len ##1 s_fail_stat)
		else $error("unread track record malformed");
	AST_DEFAULTS: assert property (
		open_reader_session |=> (parm_ff[0] == T1_DEF && parm_ff[1] == T2_DEF))
		else $error("defaults not loaded on open");
	AST_SINGLE_ARM: assert property (
		(st_ff == ST_IDLE && req_go && requested_track_set != 2'b11)
		|=> (ind_ff && st_ff == ST_ARMED))
		else $error("indicator not lit when single read armed");
	AST_IND_HOLD: assert property (
		(ind_ff && !abort_track_read && !(sw_go && pass)) |=> ind_ff)
		else $error("indicator dropped without success");
	AST_ABORT: assert property (
		(abort_track_read && st_ff != ST_IDLE) |=> (st_ff == ST_IDLE && !ind_ff))
		else $error("abort did not cancel read");
endmodule : srt_read_ctrl
`default_nettype wire

// >>> test/srt_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// card passing the read head
// ****************************************
module srt_card_model import srt_pkg::*; (
	// clock
	input  wire logic      ref_clk,
	// head pins
	output var  srt_head_t head_pins
);
	initial head_pins = '0;

	function automatic logic [7:0] enc(input logic t, input logic [6:0] d);
		// odd character parity on top used bit
		enc = t ? {3'h0, ~^d[3:0], d[3:0]} : {1'b0, ~^d[5:0], d[5:0]};
	endfunction : enc

	task automatic put(input logic t, input logic [7:0] c);
		@(negedge ref_clk);
		head_pins.trk = t;
		head_pins.chr = c;
		repeat (4) @(negedge ref_clk);
		head_pins.strobe = 1'b1;
		repeat (4) @(negedge ref_clk);
		head_pins.strobe = 1'b0;
		// released data lines do not keep the last value
		head_pins.chr = ~c;
		repeat (3) @(negedge ref_clk);
	endtask : put

	task automatic track(input logic t, input logic [6:0] d[$],
			input logic bad_par, input logic bad_lrc);
		logic [7:0] lrc;
		logic [7:0] c;
		lrc = 8'h00;
		foreach (d[i]) begin
			c = enc(t, d[i]);
			lrc = lrc ^ (t ? {4'h0, c[3:0]} : {2'h0, c[5:0]});
			if (bad_par && i == 1) begin
				c = c ^ (t ? 8'h10 : 8'h40);
			end
			put(t, c);
		end
		lrc[0] = lrc[0] ^ bad_lrc;
		// even parity on the redundancy character
		lrc = lrc | (^lrc ? (t ? 8'h10 : 8'h40) : 8'h00);
		put(t, lrc);
	endtask : track

	task automatic swipe(input logic on);
		@(negedge ref_clk);
		head_pins.active = on;
		repeat (4) @(negedge ref_clk);
	endtask : swipe
endmodule : srt_card_model
`default_nettype wire

// >>> test/srt_read_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// read control bench
// ****************************************
module srt_read_ctrl_tb_top import srt_pkg::*; ;
	logic       ref_clk, rst_b, open_reader_session, load_track_parameters;
	logic       load_track_sel, set_multitrack_policy, multitrack_policy;
	logic       track_read_request, abort_track_read;
	logic       read_done, read_busy, failure_indicator;
	logic [1:0] requested_track_set;
	srt_parm_t  load_parm;
	srt_head_t  head_pins;
	srt_rec_t   rec_out;
	int         bad_count, num_checks, cyc, dn, lst;
	logic [7:0] got[$], exp[$];
	logic [6:0] q1[$] = '{7'h05, 7'h11, 7'h22, 7'h1F};
	logic [6:0] q2[$] = '{7'h0B, 7'h03, 7'h07, 7'h0F};
	logic [6:0] q3[$] = '{7'h0D, 7'h03, 7'h07, 7'h0C};
	logic [6:0] q4[$] = '{7'h03, 7'h11, 7'h1E};

	srt_read_ctrl srt_read_ctrl_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.head_pins(head_pins), .open_reader_session(open_reader_session),
		.load_track_parameters(load_track_parameters),
		.load_track_sel(load_track_sel), .load_parm(load_parm),
		.set_multitrack_policy(set_multitrack_policy),
		.multitrack_policy(multitrack_policy),
		.track_read_request(track_read_request),
		.requested_track_set(requested_track_set),
		.abort_track_read(abort_track_read), .rec_out(rec_out),
		.read_done(read_done), .read_busy(read_busy),
		.failure_indicator(failure_indicator));
	srt_card_model srt_card_model_i (.ref_clk(ref_clk), .head_pins(head_pins));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk) begin
		if (rec_out.valid === 1'b1) begin
			got.push_back(rec_out.data);
			if (rec_out.last === 1'b1) lst = got.size();
		end
		if (read_done === 1'b1) dn++;
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			complete_run();
		end
	end

	task automatic check(input string nm, input logic [7:0] s, w);
		num_checks++;
		if (s !== w) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, w, s);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic flags(input logic [1:0] w);
		check("busy_ind", {6'h00, read_busy, failure_indicator}, {6'h00, w});
	endtask : flags

	task automatic req(input logic [1:0] s);
		@(negedge ref_clk);
		requested_track_set = s;
		track_read_request = 1'b1;
		@(negedge ref_clk);
		track_read_request = 1'b0;
	endtask : req

	task automatic policy(input logic p);
		@(negedge ref_clk);
		multitrack_policy = p;
		set_multitrack_policy = 1'b1;
		@(negedge ref_clk);
		set_multitrack_policy = 1'b0;
	endtask : policy

	task automatic load(input logic s, input srt_parm_t v);
		@(negedge ref_clk);
		load_track_sel = s;
		load_parm = v;
		load_track_parameters = 1'b1;
		@(negedge ref_clk);
		load_track_parameters = 1'b0;
	endtask : load

	task automatic abort();
		@(negedge ref_clk);
		abort_track_read = 1'b1;
		@(negedge ref_clk);
		abort_track_read = 1'b0;
	endtask : abort

	task automatic add(input logic t, input logic [6:0] d[$], input logic ok,
			input logic blank);
		if (ok) begin
			exp.push_back(8'(d.size() + 1));
			exp.push_back(t ? 8'h02 : 8'h04);
			foreach (d[i]) exp.push_back({1'b0, d[i]});
		end else begin
			exp.push_back(LEN_UNREAD);
			exp.push_back((blank ? 8'h80 : 8'h40) | (t ? 8'h02 : 8'h04));
		end
	endtask : add

	task automatic rec(input int ndone);
		repeat (60) @(negedge ref_clk);
		check("rec_len", 8'(got.size()), 8'(exp.size()));
		foreach (exp[i]) check("rec_byte", i < got.size() ? got[i] : 8'hXX,
			exp[i]);
		check("done", 8'(dn), 8'(ndone));
		check("rec_last", 8'(lst), 8'(ndone * exp.size()));
		got.delete();
		exp.delete();
		dn = 0;
		lst = 0;
	endtask : rec

	task automatic one(input logic t, input logic [6:0] d[$],
			input logic bp, input logic bl);
		srt_card_model_i.swipe(1'b1);
		srt_card_model_i.track(t, d, bp, bl);
		srt_card_model_i.swipe(1'b0);
	endtask : one

	task automatic s_single();
		req(2'h1);
		flags(2'h3);
		one(1'b0, q1, 1'b0, 1'b0);
		add(1'b0, q1, 1'b1, 1'b0);
		rec(1);
		flags(2'h0);
	endtask : s_single

	task automatic s_retry();
		req(2'h2);
		one(1'b1, q2, 1'b1, 1'b0);
		rec(0);
		flags(2'h3);
		one(1'b1, q3, 1'b0, 1'b0);
		add(1'b1, q3, 1'b1, 1'b0);
		rec(1);
		flags(2'h0);
	endtask : s_retry

	task automatic s_all();
		policy(POL_ALL);
		req(2'h3);
		flags(2'h2);
		srt_card_model_i.swipe(1'b1);
		srt_card_model_i.track(1'b0, q1, 1'b0, 1'b0);
		srt_card_model_i.track(1'b1, q2, 1'b0, 1'b1);
		srt_card_model_i.swipe(1'b0);
		rec(0);
		flags(2'h3);
		abort();
		flags(2'h0);
	endtask : s_all

	task automatic s_any(input logic blank);
		logic [6:0] d[$];
		d = blank ? '{7'h11, 7'h22} : q1;
		policy(POL_ANY);
		req(2'h3);
		srt_card_model_i.swipe(1'b1);
		srt_card_model_i.track(1'b0, d, 1'b0, !blank);
		srt_card_model_i.track(1'b1, q2, 1'b0, 1'b0);
		srt_card_model_i.swipe(1'b0);
		add(1'b0, d, 1'b0, blank);
		add(1'b1, q2, 1'b1, 1'b0);
		rec(1);
	endtask : s_any

	task automatic s_load();
		load(1'b0, '{7'h03, 7'h03, 7'h1E, 7'h1E, BITS_SEVEN});
		load(1'b1, '{7'h0B, 7'h0B, 7'h0F, 7'h0F, 3'h5});
		req(2'h1);
		one(1'b0, q4, 1'b0, 1'b0);
		add(1'b0, q4, 1'b1, 1'b0);
		rec(1);
		req(2'h2);
		one(1'b1, q3, 1'b0, 1'b0);
		rec(0);
		flags(2'h3);
		abort();
		@(negedge ref_clk);
		open_reader_session = 1'b1;
		@(negedge ref_clk);
		open_reader_session = 1'b0;
		req(2'h1);
		one(1'b0, q4, 1'b0, 1'b0);
		rec(0);
		flags(2'h3);
		abort();
	endtask : s_load

	initial begin
		{rst_b, open_reader_session, load_track_parameters} = 3'h0;
		{load_track_sel, set_multitrack_policy, multitrack_policy} = 3'h0;
		{track_read_request, abort_track_read} = 2'h0;
		requested_track_set = 2'h0;
		load_parm = T1_DEF;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_b = 1'b1;
		flags(2'h0);
		s_single();
		s_retry();
		s_all();
		s_any(1'b1);
		s_any(1'b0);
		s_load();
		complete_run();
	end
endmodule : srt_read_ctrl_tb_top
`default_nettype wire
